// File: src/asc_pkg.sv
// constants and types shared by the converter status and mode control block
package asc_pkg;

   // ------------------------------------------------------------
   // special function register addresses
   // ------------------------------------------------------------
   localparam logic [7:0] STATUS_ADDR  = 8'hd8;   // bit addressable
   localparam logic [7:0] MODE_ADDR    = 8'hd1;   // byte access only
   localparam logic [4:0] STATUS_BITBASE = 5'h1b; // bit addresses d8..df

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] STATUS_RST   = 8'h00;
   localparam logic [7:0] MODE_RST     = 8'h00;
   localparam logic [7:0] RDATA_RST    = 8'h00;

   // ------------------------------------------------------------
   // status register bit positions
   // ------------------------------------------------------------
   localparam int unsigned ST_PRIMARY_READY_FLAG  = 7;   // primary ready
   localparam int unsigned ST_AUX_READY_FLAG  = 6;   // auxiliary ready
   localparam int unsigned ST_CAL   = 5;   // calibration done
   localparam int unsigned ST_NOREF = 4;   // missing reference
   localparam int unsigned ST_PRIMARY_ERROR_FLAG  = 3;   // primary error
   localparam int unsigned ST_AUX_ERROR_FLAG  = 2;   // auxiliary error

   // ------------------------------------------------------------
   // mode register bit positions
   // ------------------------------------------------------------
   localparam int unsigned MD_EN0   = 5;   // primary enable
   localparam int unsigned MD_EN1   = 4;   // auxiliary enable
   localparam int unsigned MD_LSB   = 0;   // mode field, three bits
   localparam int unsigned MD_MSB   = 2;

   // ------------------------------------------------------------
   // mode field encoding
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_PDOWN   = 3'h0,   // power-down, reset value
      MODE_IDLE    = 3'h1,   // filter and modulator held
      MODE_SINGLE  = 3'h2,   // one conversion then power-down
      MODE_CONT    = 3'h3,   // continuous conversion
      MODE_IZERO   = 3'h4,   // internal zero-scale calibration
      MODE_IFULL   = 3'h5,   // internal full-scale calibration
      MODE_SZERO   = 3'h6,   // system zero-scale calibration
      MODE_SFULL   = 3'h7    // system full-scale calibration
   } asc_mode_t;

endpackage

// File: src/asc_ctrl.sv
// status flags and mode control for the primary and auxiliary converters
`timescale 1ns/10ps

// Overview of operation
// - primary ready set on conversion or calibration end
// - primary ready cleared by software or starting mode write
// - primary ready set blocks result and calibration writes
// - auxiliary ready behaves like primary ready
// - calibration flag set when calibration completes
// - calibration flag cleared only by starting mode write
// - missing reference flag follows reference while active
// - missing external reference forces results to ones
// - primary error set on saturated result
// - primary error flags failed calibration update
// - primary error cleared by starting mode write
// - auxiliary error behaves like primary error
// - status register at d8, reset 00, bit access
// - mode register at d1, reset 00, byte access
// - primary enable runs primary in selected mode
// - primary enable cleared powers primary down
// - auxiliary enable runs auxiliary in selected mode
// - auxiliary enable cleared powers auxiliary down
// - three-bit mode field encodes eight modes
// - single conversion end returns mode to 000
// - calibration end returns mode to 000
// - any mode write resets both converters
module asc_ctrl #(
   parameter int unsigned PRIM_W = 24,   // primary result width
   parameter int unsigned AUX_W  = 16    // auxiliary result width
) (
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   // special function register access
   input  wire logic [7:0]        sfr_addr_i,
   input  wire logic              sfr_wr_i,
   input  wire logic              sfr_rd_i,
   input  wire logic [7:0]        sfr_wdata_i,
   input  wire logic              sfr_bit_wr_i,
   input  wire logic [7:0]        sfr_bit_addr_i,
   input  wire logic              sfr_bit_val_i,
   output logic [7:0]             sfr_rdata_o,
   // primary converter events
   input  wire logic              prim_done_i,
   input  wire logic [PRIM_W-1:0] prim_result_i,
   input  wire logic              prim_clamp_i,
   input  wire logic              prim_cal_done_i,
   input  wire logic              prim_cal_fail_i,
   input  wire logic              prim_ext_ref_i,
   // auxiliary converter events
   input  wire logic              aux_done_i,
   input  wire logic [AUX_W-1:0]  aux_result_i,
   input  wire logic              aux_clamp_i,
   input  wire logic              aux_cal_done_i,
   input  wire logic              aux_cal_fail_i,
   input  wire logic              aux_ext_ref_i,
   // reference detector
   input  wire logic              ref_missing_i,
   // converter control
   output logic [2:0]             mode_o,
   output logic                   prim_run_o,
   output logic                   prim_pdown_o,
   output logic                   aux_run_o,
   output logic                   aux_pdown_o,
   output logic                   both_reset_o,
   output logic                   aux_reset_o,
   // result and calibration write strobes
   output logic [PRIM_W-1:0]      prim_result_o,
   output logic                   prim_result_we_o,
   output logic                   prim_cal_we_o,
   output logic [AUX_W-1:0]       aux_result_o,
   output logic                   aux_result_we_o,
   output logic                   aux_cal_we_o
);

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------

   // mode field value starts a conversion or calibration
   function automatic logic starts_work(input logic [2:0] m);
      starts_work = (m >= asc_pkg::MODE_SINGLE);
   endfunction

   // mode field value is one of the calibrations
   function automatic logic is_cal(input logic [2:0] m);
      is_cal = m[2];
   endfunction

   // ------------------------------------------------------------
   // state record
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0]        mode;       // shared mode field
      logic              en0;        // primary enable
      logic              en1;        // auxiliary enable
      logic              primary_ready_flag;       // primary ready
      logic              aux_ready_flag;       // auxiliary ready
      logic              cal;        // calibration done
      logic              noref;      // missing reference
      logic              primary_error_flag;       // primary error
      logic              aux_error_flag;       // auxiliary error
      logic              pend0;      // primary owes a single result or calibration end
      logic              pend1;      // auxiliary owes a single result or calibration end
      logic [PRIM_W-1:0] res0;       // primary result
      logic [AUX_W-1:0]  res1;       // auxiliary result
      logic              res0_we;    // primary result strobe
      logic              res1_we;    // auxiliary result strobe
      logic              cal0_we;    // primary coefficient strobe
      logic              cal1_we;    // auxiliary coefficient strobe
      logic              rst_both;   // reset both converters
      logic              rst_aux;    // reset auxiliary only
      logic [7:0]        rdata;      // read data
   } asc_state_t;

   asc_state_t state_r;   // registered state
   asc_state_t state_nxt; // next state

   // ------------------------------------------------------------
   // decoded accesses and derived levels
   // ------------------------------------------------------------
   logic       wr_status;   // byte write to status
   logic       wr_mode;     // byte write to mode
   logic       bit_hit;     // bit write lands in status
   logic [2:0] bit_idx;     // status bit being written
   logic       act0;        // primary is running
   logic       act1;        // auxiliary is running
   logic       force0;      // primary result forced to ones
   logic       force1;      // auxiliary result forced to ones
   logic       take0;       // primary result accepted
   logic       take1;       // auxiliary result accepted
   logic       ctake0;      // primary calibration accepted
   logic       ctake1;      // auxiliary calibration accepted
   logic       conv_mode;   // mode is single or continuous
   logic [7:0] status_val;  // status as software sees it
   logic [7:0] mode_val;    // mode as software sees it

   assign wr_status = sfr_wr_i && (sfr_addr_i == asc_pkg::STATUS_ADDR);
   assign wr_mode   = sfr_wr_i && (sfr_addr_i == asc_pkg::MODE_ADDR);
   // bit writes only ever address the status register
   assign bit_hit   = sfr_bit_wr_i &&
                      (sfr_bit_addr_i[7:3] == asc_pkg::STATUS_BITBASE);
   assign bit_idx   = sfr_bit_addr_i[2:0];

   // only power-down does not count as running; idle does
   assign act0 = state_r.en0 && (state_r.mode != asc_pkg::MODE_PDOWN);
   assign act1 = state_r.en1 && (state_r.mode != asc_pkg::MODE_PDOWN);
   assign conv_mode = (state_r.mode == asc_pkg::MODE_SINGLE) ||
                      (state_r.mode == asc_pkg::MODE_CONT);

   // a lost external reference clamps the output code
   assign force0 = state_r.noref && prim_ext_ref_i;
   assign force1 = state_r.noref && aux_ext_ref_i;

   // results only land while the ready flag is clear
   assign take0  = prim_done_i && act0 && conv_mode && !state_r.primary_ready_flag;
   assign take1  = aux_done_i && act1 && conv_mode && !state_r.aux_ready_flag;
   assign ctake0 = prim_cal_done_i && act0 && is_cal(state_r.mode) &&
                   !state_r.primary_ready_flag;
   assign ctake1 = aux_cal_done_i && act1 && is_cal(state_r.mode) &&
                   !state_r.aux_ready_flag;

   // reserved positions are constant zero
   assign status_val = {state_r.primary_ready_flag, state_r.aux_ready_flag, state_r.cal, state_r.noref,
                        state_r.primary_error_flag, state_r.aux_error_flag, 2'b00};
   assign mode_val   = {2'b00, state_r.en0, state_r.en1, 1'b0,
                        state_r.mode};

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   // order matters: software clears first, hardware sets last, so a
   // hardware set in the clearing cycle wins over the clear
   always_comb begin
      state_nxt          = state_r;
      state_nxt.res0_we  = 1'b0;
      state_nxt.res1_we  = 1'b0;
      state_nxt.cal0_we  = 1'b0;
      state_nxt.cal1_we  = 1'b0;
      state_nxt.rst_both = 1'b0;
      state_nxt.rst_aux  = 1'b0;

      // read data captured on the read strobe
      if (sfr_rd_i) begin
         unique case (sfr_addr_i)
            asc_pkg::STATUS_ADDR: begin
               state_nxt.rdata = status_val;
            end
            asc_pkg::MODE_ADDR: begin
               state_nxt.rdata = mode_val;
            end
            default: begin
               state_nxt.rdata = asc_pkg::RDATA_RST;   // unmapped reads zero
            end
         endcase
      end

      // direct software access to the ready flags
      if (wr_status) begin
         state_nxt.primary_ready_flag = sfr_wdata_i[asc_pkg::ST_PRIMARY_READY_FLAG];
         state_nxt.aux_ready_flag = sfr_wdata_i[asc_pkg::ST_AUX_READY_FLAG];
      end
      if (bit_hit) begin
         // other status bits are hardware owned
         if (bit_idx == 3'(asc_pkg::ST_PRIMARY_READY_FLAG)) begin
            state_nxt.primary_ready_flag = sfr_bit_val_i;
         end
         if (bit_idx == 3'(asc_pkg::ST_AUX_READY_FLAG)) begin
            state_nxt.aux_ready_flag = sfr_bit_val_i;
         end
      end

      // single conversion and calibration bookkeeping: done events count even when
      // blocked, since the converter still finished its cycle
      if (prim_done_i || prim_cal_done_i) begin
         state_nxt.pend0 = 1'b0;
      end
      if (aux_done_i || aux_cal_done_i) begin
         state_nxt.pend1 = 1'b0;
      end
      if ((state_r.pend0 || state_r.pend1) &&
          !state_nxt.pend0 && !state_nxt.pend1) begin
         state_nxt.mode = asc_pkg::MODE_PDOWN;
      end

      // mode register write
      if (wr_mode) begin
         state_nxt.mode = sfr_wdata_i[asc_pkg::MD_MSB:asc_pkg::MD_LSB];
         state_nxt.en0  = sfr_wdata_i[asc_pkg::MD_EN0];
         state_nxt.en1  = sfr_wdata_i[asc_pkg::MD_EN1];
         // a rewrite of the same value still restarts
         state_nxt.rst_both = 1'b1;
         state_nxt.rst_aux  = 1'b1;
         // an auxiliary enable rise alone would reset only the auxiliary,
         // but it always arrives through this same write, so both restart
         if (!state_r.en1 && sfr_wdata_i[asc_pkg::MD_EN1]) begin
            state_nxt.rst_aux = 1'b1;
         end
         if (starts_work(sfr_wdata_i[asc_pkg::MD_MSB:asc_pkg::MD_LSB])) begin
            state_nxt.primary_ready_flag = 1'b0;
            state_nxt.aux_ready_flag = 1'b0;
            state_nxt.cal  = 1'b0;
            state_nxt.primary_error_flag = 1'b0;
            state_nxt.aux_error_flag = 1'b0;
         end
         // continuous mode never owes a final result
         if ((sfr_wdata_i[asc_pkg::MD_MSB:asc_pkg::MD_LSB] == asc_pkg::MODE_SINGLE) ||
             is_cal(sfr_wdata_i[asc_pkg::MD_MSB:asc_pkg::MD_LSB])) begin
            state_nxt.pend0 = sfr_wdata_i[asc_pkg::MD_EN0];
            state_nxt.pend1 = sfr_wdata_i[asc_pkg::MD_EN1];
         end else begin
            state_nxt.pend0 = 1'b0;
            state_nxt.pend1 = 1'b0;
         end
      end

      // reference detector is only meaningful while a converter is running, idle included
      state_nxt.noref = (act0 || act1) && ref_missing_i;

      // primary conversion result
      if (take0) begin
         state_nxt.res0    = force0 ? {PRIM_W{1'b1}} : prim_result_i;
         state_nxt.res0_we = 1'b1;
         state_nxt.primary_ready_flag    = 1'b1;
         if (prim_clamp_i || force0) begin
            state_nxt.primary_error_flag = 1'b1;
         end
      end

      // auxiliary conversion result
      if (take1) begin
         state_nxt.res1    = force1 ? {AUX_W{1'b1}} : aux_result_i;
         state_nxt.res1_we = 1'b1;
         state_nxt.aux_ready_flag    = 1'b1;
         if (aux_clamp_i || force1) begin
            state_nxt.aux_error_flag = 1'b1;
         end
      end

      // primary calibration end: a failure withholds the coefficients
      if (ctake0) begin
         state_nxt.primary_ready_flag    = 1'b1;
         state_nxt.cal     = 1'b1;
         state_nxt.cal0_we = !prim_cal_fail_i;
         if (prim_cal_fail_i) begin
            state_nxt.primary_error_flag = 1'b1;
         end
      end

      // auxiliary calibration end
      if (ctake1) begin
         state_nxt.aux_ready_flag    = 1'b1;
         state_nxt.cal     = 1'b1;
         state_nxt.cal1_we = !aux_cal_fail_i;
         if (aux_cal_fail_i) begin
            state_nxt.aux_error_flag = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_r       <= '0;
         state_r.mode  <= asc_pkg::MODE_PDOWN;
         state_r.en0   <= asc_pkg::MODE_RST[asc_pkg::MD_EN0];
         state_r.en1   <= asc_pkg::MODE_RST[asc_pkg::MD_EN1];
         state_r.primary_ready_flag  <= asc_pkg::STATUS_RST[asc_pkg::ST_PRIMARY_READY_FLAG];
         state_r.aux_ready_flag  <= asc_pkg::STATUS_RST[asc_pkg::ST_AUX_READY_FLAG];
         state_r.cal   <= asc_pkg::STATUS_RST[asc_pkg::ST_CAL];
         state_r.noref <= asc_pkg::STATUS_RST[asc_pkg::ST_NOREF];
         state_r.primary_error_flag  <= asc_pkg::STATUS_RST[asc_pkg::ST_PRIMARY_ERROR_FLAG];
         state_r.aux_error_flag  <= asc_pkg::STATUS_RST[asc_pkg::ST_AUX_ERROR_FLAG];
         state_r.rdata <= asc_pkg::RDATA_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // run and power-down are decoded levels of registered state
   assign mode_o           = state_r.mode;
   assign prim_run_o       = act0;
   assign prim_pdown_o     = !act0;
   assign aux_run_o        = act1;
   assign aux_pdown_o      = !act1;
   assign both_reset_o     = state_r.rst_both;
   assign aux_reset_o      = state_r.rst_aux;
   assign prim_result_o    = state_r.res0;
   assign prim_result_we_o = state_r.res0_we;
   assign prim_cal_we_o    = state_r.cal0_we;
   assign aux_result_o     = state_r.res1;
   assign aux_result_we_o  = state_r.res1_we;
   assign aux_cal_we_o     = state_r.cal1_we;
   assign sfr_rdata_o      = state_r.rdata;

endmodule

// File: tb/asc_ctrl_sva.sv
// assertion checker for the converter status and mode control block
`timescale 1ns/10ps
module asc_ctrl_sva #(
   parameter int unsigned PRIM_W = 24,
   parameter int unsigned AUX_W  = 16
) (
   input wire logic              clock_i,
   input wire logic              rst_i,
   input wire logic [7:0]        sfr_addr_i,
   input wire logic              sfr_wr_i,
   input wire logic [7:0]        sfr_wdata_i,
   input wire logic              prim_done_i,
   input wire logic [PRIM_W-1:0] prim_result_i,
   input wire logic              prim_cal_done_i,
   input wire logic              prim_cal_fail_i,
   input wire logic              prim_ext_ref_i,
   input wire logic              aux_done_i,
   input wire logic              aux_cal_done_i,
   input wire logic              ref_missing_i,
   input wire logic [2:0]        mode_o,
   input wire logic              prim_run_o,
   input wire logic              prim_pdown_o,
   input wire logic              aux_run_o,
   input wire logic              aux_pdown_o,
   input wire logic              both_reset_o,
   input wire logic              aux_reset_o,
   input wire logic [PRIM_W-1:0] prim_result_o,
   input wire logic              prim_result_we_o,
   input wire logic              prim_cal_we_o
);
   // ----------------------------------------
   // helper state
   // ----------------------------------------
   logic [7:0] wd_q;      // last write data
   logic       miss_q;    // mirrors the missing reference flag
   wire        quiet = !(prim_done_i | prim_cal_done_i | aux_done_i | aux_cal_done_i);

   // mirrors registered so the antecedents need no deep history
   always_ff @(posedge clock_i) begin
      wd_q   <= sfr_wdata_i;
      miss_q <= (prim_run_o | aux_run_o) & ref_missing_i;
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_wr_rst;
      sfr_wr_i && sfr_addr_i == asc_pkg::MODE_ADDR |=> both_reset_o && aux_reset_o;
   endproperty
   a_wr_rst: assert property (p_wr_rst) else $error("mode write gave no reset");
   property p_mode;
      quiet && sfr_wr_i && sfr_addr_i == asc_pkg::MODE_ADDR |=> mode_o == wd_q[2:0]
         && prim_run_o == (wd_q[5] && wd_q[2:0] != 3'h0)
         && aux_run_o == (wd_q[4] && wd_q[2:0] != 3'h0);
   endproperty
   a_mode: assert property (p_mode) else $error("mode or enables wrong after write");
   property p_pdown;
      prim_pdown_o != prim_run_o && aux_pdown_o != aux_run_o
         && (mode_o != 3'h0 || (prim_pdown_o && aux_pdown_o));
   endproperty
   a_pdown: assert property (p_pdown) else $error("power-down not inverse of run");
   property p_result;
      prim_done_i && prim_run_o && !prim_ext_ref_i ##1 prim_result_we_o
         |-> prim_result_o == $past(prim_result_i);
   endproperty
   a_result: assert property (p_result) else $error("accepted result differs");
   property p_force;
      prim_done_i && prim_run_o && prim_ext_ref_i && miss_q ##1 prim_result_we_o
         |-> prim_result_o == {PRIM_W{1'h1}};
   endproperty
   a_force: assert property (p_force) else $error("result not forced to ones");
   property p_single;
      prim_result_we_o && $past(mode_o) == 3'h2 && !$past(aux_run_o) && !$past(sfr_wr_i)
         |-> mode_o == 3'h0;
   endproperty
   a_single: assert property (p_single) else $error("single end kept mode");
   property p_cal;
      prim_cal_we_o && !$past(aux_run_o) && !$past(sfr_wr_i) |-> mode_o == 3'h0;
   endproperty
   a_cal: assert property (p_cal) else $error("calibration end kept mode");
   property p_calfail;
      prim_cal_done_i && prim_cal_fail_i |=> !prim_cal_we_o;
   endproperty
   a_calfail: assert property (p_calfail) else $error("failed calibration wrote");

   c_res: cover property (prim_result_we_o);
   c_cal: cover property (prim_cal_we_o);
   c_rst: cover property (both_reset_o);
endmodule

// File: tb/asc_ctrl_bench.sv
// self-checking bench for the converter status and mode control block
`timescale 1ns/10ps
module asc_ctrl_bench;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic        clock_i = 1'h0;
   logic        rst_i   = 1'h1;
   logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_bit_addr_i = 8'h00, sfr_rdata_o;
   logic        sfr_wr_i = 1'h0, sfr_rd_i = 1'h0, sfr_bit_wr_i = 1'h0, sfr_bit_val_i = 1'h0;
   logic [23:0] prim_result_i = 24'h00_0000, prim_result_o, res;
   logic [15:0] aux_result_i = 16'h0000, aux_result_o;
   logic        prim_done_i = 1'h0, prim_clamp_i = 1'h0, prim_cal_done_i = 1'h0;
   logic        aux_done_i = 1'h0, aux_clamp_i = 1'h0, aux_cal_done_i = 1'h0;
   logic        prim_cal_fail_i = 1'h0, aux_cal_fail_i = 1'h0, ref_missing_i = 1'h0;
   logic        prim_ext_ref_i = 1'h0, aux_ext_ref_i = 1'h0;
   logic [2:0]  mode_o;
   logic        prim_run_o, prim_pdown_o, aux_run_o, aux_pdown_o, both_reset_o, aux_reset_o;
   logic        prim_result_we_o, prim_cal_we_o, aux_result_we_o, aux_cal_we_o;
   logic [31:0] seed = 32'h0000_8719;   // fixed so runs repeat
   logic [7:0]  d;
   int          err_count = 0;
   int          checks_done = 0;

   asc_ctrl dut (.clock_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
      .sfr_bit_wr_i, .sfr_bit_addr_i, .sfr_bit_val_i, .sfr_rdata_o, .prim_done_i,
      .prim_result_i, .prim_clamp_i, .prim_cal_done_i, .prim_cal_fail_i, .prim_ext_ref_i,
      .aux_done_i, .aux_result_i, .aux_clamp_i, .aux_cal_done_i, .aux_cal_fail_i,
      .aux_ext_ref_i, .ref_missing_i, .mode_o, .prim_run_o, .prim_pdown_o, .aux_run_o,
      .aux_pdown_o, .both_reset_o, .aux_reset_o, .prim_result_o, .prim_result_we_o,
      .prim_cal_we_o, .aux_result_o, .aux_result_we_o, .aux_cal_we_o);

   // 125 MHz core clock
   always #4 clock_i = ~clock_i;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // a converter runs only when enabled and out of power-down
   function automatic logic run_exp(input logic [7:0] v, input int b);
      return v[b] && (v[2:0] != 3'h0);
   endfunction

   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // byte write, one-cycle strobe launched off the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clock_i);
      sfr_addr_i = a;
      sfr_wdata_i = v;
      sfr_wr_i = 1'h1;
      @(negedge clock_i);
      sfr_wr_i = 1'h0;
   endtask

   task automatic bwr(input logic [7:0] a, input logic v);
      @(negedge clock_i);
      sfr_bit_addr_i = a;
      sfr_bit_val_i = v;
      sfr_bit_wr_i = 1'h1;
      @(negedge clock_i);
      sfr_bit_wr_i = 1'h0;
   endtask

   // read data is registered, so it is settled one falling edge later
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(negedge clock_i);
      sfr_addr_i = a;
      sfr_rd_i = 1'h1;
      @(negedge clock_i);
      sfr_rd_i = 1'h0;
      chk("rdata", {16'h0000, e}, {16'h0000, sfr_rdata_o & m});
   endtask

   // k: 0 primary done, 1 primary cal, 2 aux done, 3 aux cal; f is clamp or fail
   task automatic evt(input int k, input logic [23:0] r, input logic f);
      @(negedge clock_i);
      prim_result_i = r;
      aux_result_i = r[15:0];
      {prim_clamp_i, aux_clamp_i, prim_cal_fail_i, aux_cal_fail_i} = {4{f}};
      {prim_done_i, prim_cal_done_i, aux_done_i, aux_cal_done_i} = 4'h8 >> k;
      @(negedge clock_i);
      {prim_done_i, prim_cal_done_i, aux_done_i, aux_cal_done_i} = 4'h0;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clock_i);
      @(negedge clock_i);
      rst_i = 1'h0;
      chk("pdown", 24'h1, prim_pdown_o & aux_pdown_o);
      rd(8'hd8, 8'h00, 8'hff);
      rd(8'hd1, 8'h00, 8'hff);
      rd(8'h80, 8'h00, 8'hff);
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         d = {seed[7:3], i[2:0]};
         wr(8'hd1, d);
         chk("reset", 24'h1, both_reset_o & aux_reset_o);
         chk("mode", i[2:0], mode_o);
         chk("prun", run_exp(d, 5), prim_run_o);
         chk("arun", run_exp(d, 4), aux_run_o);
         chk("apdn", !run_exp(d, 4), aux_pdown_o);
         rd(8'hd1, d & 8'h37, 8'hff);
      end
      // single conversion, then continuous with clamp and blocking
      wr(8'hd1, 8'h22);
      seed = xs(seed);
      res = seed[23:0];
      evt(0, res, 1'h0);
      chk("we", 24'h1, prim_result_we_o);
      chk("res", res, prim_result_o);
      chk("mode", 24'h0, mode_o);
      rd(8'hd8, 8'h80, 8'hff);
      wr(8'hd1, 8'h23);
      rd(8'hd8, 8'h00, 8'hff);
      evt(0, res, 1'h1);
      rd(8'hd8, 8'h88, 8'hff);
      evt(0, ~res, 1'h0);
      chk("we", 24'h0, prim_result_we_o);
      bwr(8'hdf, 1'h0);
      rd(8'hd8, 8'h08, 8'hff);
      evt(0, ~res, 1'h0);
      chk("res", ~res, prim_result_o);
      wr(8'hd1, 8'h23);
      rd(8'hd8, 8'h00, 8'hff);
      // missing external reference while running, then while powered down
      prim_ext_ref_i = 1'h1;
      ref_missing_i = 1'h1;
      rd(8'hd8, 8'h10, 8'hff);
      evt(0, res, 1'h0);
      chk("res", 24'hff_ffff, prim_result_o);
      rd(8'hd8, 8'h98, 8'hff);
      ref_missing_i = 1'h0;
      rd(8'hd8, 8'h88, 8'hff);
      wr(8'hd1, 8'h00);
      chk("pdn", 24'h1, prim_pdown_o);
      ref_missing_i = 1'h1;
      rd(8'hd8, 8'h88, 8'hff);
      ref_missing_i = 1'h0;
      prim_ext_ref_i = 1'h0;
      // primary calibration, good and failed
      wr(8'hd1, 8'h24);
      evt(1, res, 1'h0);
      chk("cwe", 24'h1, prim_cal_we_o);
      chk("mode", 24'h0, mode_o);
      rd(8'hd8, 8'ha0, 8'hff);
      wr(8'hd1, 8'h21);
      rd(8'hd8, 8'ha0, 8'hff);
      wr(8'hd1, 8'h25);
      evt(1, res, 1'h1);
      chk("cwe", 24'h0, prim_cal_we_o);
      rd(8'hd8, 8'h88, 8'hdf);
      // auxiliary converter
      wr(8'hd1, 8'h13);
      evt(2, res, 1'h1);
      chk("awe", 24'h1, aux_result_we_o);
      chk("ares", res[15:0], aux_result_o);
      evt(2, res, 1'h0);
      chk("awe", 24'h0, aux_result_we_o);
      rd(8'hd8, 8'h44, 8'hff);
      wr(8'hd1, 8'h14);
      evt(3, res, 1'h0);
      chk("acwe", 24'h1, aux_cal_we_o);
      rd(8'hd8, 8'h60, 8'hff);
      // software access to status: only the ready bits take writes
      wr(8'hd8, 8'hff);
      bwr(8'hd8, 1'h1);
      bwr(8'hdd, 1'h0);
      rd(8'hd8, 8'he0, 8'hff);
      bwr(8'hdf, 1'h0);
      rd(8'hd8, 8'h60, 8'hff);
      end_sim;
   end

   // watchdog: the sequence needs about 122 cycles
   initial begin
      repeat (3000) @(posedge clock_i);
      err_count++;
      end_sim;
   end
endmodule

bind asc_ctrl asc_ctrl_sva #(.PRIM_W(PRIM_W), .AUX_W(AUX_W)) u_sva (.clock_i, .rst_i,
   .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .prim_done_i, .prim_result_i, .prim_cal_done_i,
   .prim_cal_fail_i, .prim_ext_ref_i, .aux_done_i, .aux_cal_done_i, .ref_missing_i, .mode_o,
   .prim_run_o, .prim_pdown_o, .aux_run_o, .aux_pdown_o, .both_reset_o, .aux_reset_o,
   .prim_result_o, .prim_result_we_o, .prim_cal_we_o);
